// >>> core/see_core.sv
// Serial EEPROM command front end: link shifter, status and array
`timescale 1ns/1ps
module see_core #(
   parameter int         WC_CYC   = see_pkg::WC_CYC,
   parameter logic [7:0] SIG_BYTE = 8'h5a  // Arbitrary value
) (
   // System clock and reset
   input  logic sys_clk,
   input  logic rst,
   // Serial link
   input  logic sck,
   input  logic cs_n,
   input  logic si,
   input  logic hold_n,
   input  logic wp_n,
   output logic so_out,
   output logic so_oe_n
);
   // Link side state
   logic          frame_new_r;
   logic [5:0]    cnt_r;
   logic [2:0]    bitpos_r;
   logic [31:0]   sh_r;
   logic [7:0]    opcode_r;
   logic [7:0]    sr_byte_r;
   logic [16:0]   addr_r;
   logic          frm_tog_r;
   logic          buf_ok_r;
   logic [7:0]    pbuf [256];
   logic [255:0]  pval_r;
   logic [7:0]    st_s1_r;
   logic [7:0]    st_s2_r;
   logic          dp_s1_r;
   logic          dp_s2_r;
   logic          so_r;
   logic          so_oe_n_r;
   logic [5:0]    cur_cnt;
   logic [5:0]    nxt_cnt;
   logic [2:0]    idx;
   logic [7:0]    byte_in;
   logic [7:0]    out_byte;
   logic          byte_end;
   logic          busy_s;
   logic          deep_s;
   logic          drive;
   // System side state
   logic [7:0]    mem [2**see_pkg::ADDR_W];
   logic          cs_s1_r;
   logic          cs_s2_r;
   logic          cs_s3_r;
   logic          wp_s1_r;
   logic          wp_s2_r;
   logic          tog_seen_r;
   logic          latch_r;
   logic          deep_r;
   logic          pen_r;
   logic [1:0]    bp_r;
   logic          busy_r;
   logic [31:0]   tmr_r;
   logic          sweep_r;
   logic          sw_erase_r;
   logic [16:0]   sw_addr_r;
   logic [16:0]   sw_last_r;
   logic [7:0]    status;
   logic          frame_end;
   logic          idle;
   logic          act;
   logic          sr_lock;
   logic          ok_lset;
   logic          ok_lclr;
   logic          ok_srwr;
   logic          ok_write;
   logic          ok_pgerase;
   logic          ok_scerase;
   logic          ok_ce;
   logic          ok_sleep;
   logic          ok_wake;
   logic          start;

   // Address falls in a protected block
   function automatic logic blocked(input logic [1:0] bp, input logic [16:0] a);
      unique case (bp)
         2'h0: blocked = 1'b0;
         2'h1: blocked = (a >= see_pkg::Q3_BASE);
         2'h2: blocked = (a >= see_pkg::HALF_BASE);
         2'h3: blocked = 1'b1;
      endcase
   endfunction : blocked

   // Position within the current frame
   assign cur_cnt  = frame_new_r ? 6'h00 : cnt_r;
   assign nxt_cnt  = cur_cnt + 6'h01;
   assign idx      = frame_new_r ? 3'h0 : bitpos_r;
   assign byte_in  = {sh_r[6:0], si};
   assign byte_end = hold_n && (cur_cnt >= see_pkg::CNT_ADDR) && (idx == 3'h7);
   assign busy_s   = st_s2_r[see_pkg::ST_BUSY];
   assign deep_s   = dp_s2_r;

   // Frame start flag, set while select is high
   always_ff @(posedge sck or posedge cs_n or posedge rst) begin
      if (cs_n || rst) begin
         frame_new_r <= 1'b1;
      end else if (hold_n) begin
         frame_new_r <= 1'b0;
      end
   end

   // Bit counters and input shifter
   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         cnt_r     <= 6'h00;
         bitpos_r  <= 3'h0;
         sh_r      <= 32'h0;
         frm_tog_r <= 1'b0;
      end else if (hold_n) begin
         cnt_r    <= (cur_cnt == see_pkg::CNT_DATA) ? see_pkg::CNT_DATA : nxt_cnt;
         bitpos_r <= idx + 3'h1;
         sh_r     <= {sh_r[30:0], si};
         if (frame_new_r) begin
            frm_tog_r <= ~frm_tog_r;
         end
      end
   end

   // Opcode, status byte and address pointer
   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         opcode_r    <= 8'h00;
         sr_byte_r   <= 8'h00;
         addr_r      <= 17'h0;
      end else if (hold_n) begin
         if (nxt_cnt == see_pkg::CNT_OP) begin
            opcode_r <= byte_in;
         end
         if (nxt_cnt == see_pkg::CNT_SR) begin
            sr_byte_r <= byte_in;
         end
         if (nxt_cnt == see_pkg::CNT_ADDR) begin
            addr_r <= {sh_r[15:0], si};
         end else if (byte_end && opcode_r == see_pkg::OP_READ) begin
            addr_r <= addr_r + 17'h1;
         end else if (byte_end && opcode_r == see_pkg::OP_WRITE && buf_ok_r) begin
            addr_r[7:0] <= addr_r[7:0] + 8'h01;
         end
      end
   end

   // Page buffer fill flags; untouched while a commit reads them
   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         pval_r   <= '0;
         buf_ok_r <= 1'b0;
      end else if (hold_n) begin
         if (frame_new_r) begin
            buf_ok_r <= 1'b0;
         end else if (nxt_cnt == see_pkg::CNT_ADDR) begin
            buf_ok_r <= !busy_s;
         end
         if (nxt_cnt == see_pkg::CNT_ADDR && !busy_s) begin
            pval_r <= '0;
         end else if (byte_end && opcode_r == see_pkg::OP_WRITE && buf_ok_r) begin
            pval_r[addr_r[7:0]] <= 1'b1;
         end
      end
   end

   // Page buffer data
   always_ff @(posedge sck) begin
      if (byte_end && opcode_r == see_pkg::OP_WRITE && buf_ok_r) begin
         pbuf[addr_r[7:0]] <= byte_in;
      end
   end

   // Status and sleep state into the link domain
   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         st_s1_r <= 8'h00;
         st_s2_r <= 8'h00;
         dp_s1_r <= 1'b0;
         dp_s2_r <= 1'b0;
      end else begin
         st_s1_r <= status;
         st_s2_r <= st_s1_r;
         dp_s1_r <= deep_r;
         dp_s2_r <= dp_s1_r;
      end
   end

   // Byte chosen for the output shifter
   always_comb begin
      unique case (opcode_r)
         see_pkg::OP_SR_RD: out_byte = st_s2_r;
         see_pkg::OP_WAKE:  out_byte = SIG_BYTE;
         default:          out_byte = mem[addr_r];
      endcase
   end

   // When the output drives
   assign drive = !frame_new_r && (
      (opcode_r == see_pkg::OP_SR_RD && cnt_r >= see_pkg::CNT_OP && !deep_s) ||
      (cnt_r >= see_pkg::CNT_ADDR && opcode_r == see_pkg::OP_WAKE) ||
      (cnt_r >= see_pkg::CNT_ADDR && opcode_r == see_pkg::OP_READ &&
       !busy_s && !deep_s));

   // Output shifter on the falling clock
   always_ff @(negedge sck or posedge cs_n or posedge rst) begin
      if (cs_n || rst) begin
         so_r      <= 1'b0;
         so_oe_n_r <= 1'b1;
      end else if (!hold_n) begin
         so_oe_n_r <= 1'b1;
      end else if (drive) begin
         so_r      <= out_byte[~bitpos_r];
         so_oe_n_r <= 1'b0;
      end else begin
         so_oe_n_r <= 1'b1;
      end
   end

   assign so_out  = so_r;
   assign so_oe_n = so_oe_n_r;

   // Select and protect pin synchronisers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cs_s1_r    <= 1'b1;
         cs_s2_r    <= 1'b1;
         cs_s3_r    <= 1'b1;
         wp_s1_r    <= 1'b1;
         wp_s2_r    <= 1'b1;
         tog_seen_r <= 1'b0;
      end else begin
         cs_s1_r <= cs_n;
         cs_s2_r <= cs_s1_r;
         cs_s3_r <= cs_s2_r;
         wp_s1_r <= wp_n;
         wp_s2_r <= wp_s1_r;
         if (cs_s2_r && !cs_s3_r) begin
            tog_seen_r <= frm_tog_r;
         end
      end
   end

   // Frame summary decode at select rise
   assign frame_end = cs_s2_r && !cs_s3_r && (frm_tog_r != tog_seen_r);
   assign idle      = frame_end && !busy_r;
   assign act       = idle && !deep_r;
   assign sr_lock   = !wp_s2_r && pen_r;
   assign ok_lset   = act && opcode_r == see_pkg::OP_LSET &&
                      cnt_r == see_pkg::CNT_OP;
   assign ok_lclr   = act && opcode_r == see_pkg::OP_LCLR && cnt_r == see_pkg::CNT_OP;
   assign ok_srwr   = act && opcode_r == see_pkg::OP_SR_WR && cnt_r == see_pkg::CNT_SR &&
                      latch_r && !sr_lock;
   assign ok_write  = act && opcode_r == see_pkg::OP_WRITE && buf_ok_r &&
                      cnt_r == see_pkg::CNT_DATA && bitpos_r == 3'h0 && latch_r &&
                      !blocked(bp_r, {addr_r[16:8], 8'h00});
   assign ok_pgerase = act && opcode_r == see_pkg::OP_PG_ER &&
                       cnt_r == see_pkg::CNT_ADDR &&
                       latch_r && !blocked(bp_r, addr_r);
   assign ok_scerase = act && opcode_r == see_pkg::OP_SC_ER &&
                       cnt_r == see_pkg::CNT_ADDR &&
                       latch_r && !blocked(bp_r, {addr_r[16:15], 15'h0});
   assign ok_ce     = act && opcode_r == see_pkg::OP_CE && cnt_r == see_pkg::CNT_OP &&
                      latch_r && bp_r == 2'h0;
   assign ok_sleep  = act && opcode_r == see_pkg::OP_SLEEP && cnt_r == see_pkg::CNT_OP;
   assign ok_wake   = idle && opcode_r == see_pkg::OP_WAKE && cnt_r >= see_pkg::CNT_OP;
   assign start     = ok_write || ok_pgerase || ok_scerase || ok_ce || ok_srwr;

   // Write enable latch and deep sleep
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         latch_r <= 1'b0;
         deep_r  <= 1'b0;
      end else begin
         if (ok_lset) begin
            latch_r <= 1'b1;
         end else if (start || ok_lclr) begin
            latch_r <= 1'b0;
         end
         if (ok_sleep) begin
            deep_r <= 1'b1;
         end else if (ok_wake) begin
            deep_r <= 1'b0;
         end
      end
   end

   // Nonvolatile protect bits
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pen_r <= see_pkg::PEN_RST;
         bp_r  <= see_pkg::BP_RST;
      end else if (ok_srwr) begin
         pen_r <= sr_byte_r[see_pkg::ST_PEN];
         bp_r  <= sr_byte_r[see_pkg::ST_BPM:see_pkg::ST_BPL];
      end
   end

   // Status word
   assign status = {pen_r, 3'h0, bp_r, latch_r, busy_r};

   // Self-timed cycle and busy flag
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         busy_r <= 1'b0;
         tmr_r  <= 32'h0;
      end else if (start) begin
         busy_r <= 1'b1;
         tmr_r  <= 32'(WC_CYC - 1);
      end else if (tmr_r != 32'h0) begin
         tmr_r <= tmr_r - 32'h1;
      end else if (!sweep_r) begin
         busy_r <= 1'b0;
      end
   end

   // Array sweep range for commit or erase
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sweep_r    <= 1'b0;
         sw_erase_r <= 1'b0;
         sw_addr_r  <= 17'h0;
         sw_last_r  <= 17'h0;
      end else if (ok_write || ok_pgerase) begin
         sweep_r    <= 1'b1;
         sw_erase_r <= ok_pgerase;
         sw_addr_r  <= {addr_r[16:8], 8'h00};
         sw_last_r  <= {addr_r[16:8], see_pkg::PAGE_LAST_OFS};
      end else if (ok_scerase) begin
         sweep_r    <= 1'b1;
         sw_erase_r <= 1'b1;
         sw_addr_r  <= {addr_r[16:15], 15'h0};
         sw_last_r  <= {addr_r[16:15], see_pkg::SECT_LAST_OFS};
      end else if (ok_ce) begin
         sweep_r    <= 1'b1;
         sw_erase_r <= 1'b1;
         sw_addr_r  <= 17'h0;
         sw_last_r  <= see_pkg::ARRAY_LAST;
      end else if (sweep_r) begin
         if (sw_addr_r == sw_last_r) begin
            sweep_r <= 1'b0;
         end else begin
            sw_addr_r <= sw_addr_r + 17'h1;
         end
      end
   end

   // Array storage, written one byte per cycle
   always_ff @(posedge sys_clk) begin
      if (sweep_r && (sw_erase_r || pval_r[sw_addr_r[7:0]])) begin
         mem[sw_addr_r] <= sw_erase_r ? see_pkg::ERASED : pbuf[sw_addr_r[7:0]];
      end
   end

   // Link side checks
   a_opcode_capture: assert property (
      @(posedge sck) disable iff (rst)
      (hold_n && nxt_cnt == see_pkg::CNT_OP) |=> opcode_r == $past(byte_in))
      else $error("opcode not captured on eighth edge");
   a_first_bit: assert property (
      @(posedge sck) disable iff (rst)
      (frame_new_r && hold_n) |=> (cnt_r == 6'h01 && sh_r[0] == $past(si)))
      else $error("first bit not taken on first edge");
   a_hold_freeze: assert property (
      @(posedge sck) disable iff (rst)
      !hold_n |=> ($stable(cnt_r) && $stable(bitpos_r) && $stable(addr_r)))
      else $error("transfer moved while paused");
   a_read_wrap: assert property (
      @(posedge sck) disable iff (rst)
      (byte_end && opcode_r == see_pkg::OP_READ) |=> addr_r == 17'($past(addr_r) + 17'h1))
      else $error("read pointer did not advance");
   a_page_wrap: assert property (
      @(posedge sck) disable iff (rst)
      (byte_end && opcode_r == see_pkg::OP_WRITE && buf_ok_r) |=>
      (addr_r[16:8] == $past(addr_r[16:8]) &&
       addr_r[7:0] == 8'($past(addr_r[7:0]) + 8'h01)))
      else $error("write pointer left its page");
   a_busy_no_read: assert property (
      @(posedge sck) disable iff (rst)
      (busy_s && opcode_r == see_pkg::OP_READ) |-> so_oe_n_r)
      else $error("array read served while busy");
   a_idle_float: assert property (
      @(posedge sck) disable iff (rst)
      (!frame_new_r && cnt_r < see_pkg::CNT_OP) |-> so_oe_n_r)
      else $error("output driven during opcode");
   // System side checks
   a_latch_clear: assert property (
      @(posedge sys_clk) disable iff (rst)
      $rose(sweep_r) |-> !latch_r)
      else $error("latch still set after start");
   a_latch_set: assert property (
      @(posedge sys_clk) disable iff (rst)
      ok_lset |=> latch_r ##1 (latch_r || start || ok_lclr))
      else $error("latch set command lost");
   a_cycle_time: assert property (
      @(posedge sys_clk) disable iff (rst)
      start |=> (busy_r && tmr_r == 32'(WC_CYC - 1)))
      else $error("write cycle length wrong");
   a_busy_end: assert property (
      @(posedge sys_clk) disable iff (rst)
      (busy_r && tmr_r == 32'h0 && !sweep_r && !start) |=> !busy_r)
      else $error("busy flag stuck");
   a_sr_lock: assert property (
      @(posedge sys_clk) disable iff (rst)
      (sr_lock || !ok_srwr) |=> ($stable(pen_r) && $stable(bp_r)))
      else $error("protect bits changed while locked");
   c_read_wrap: cover property (
      @(posedge sck) disable iff (rst)
      byte_end && opcode_r == see_pkg::OP_READ && addr_r == see_pkg::ARRAY_LAST);
   c_status_busy: cover property (
      @(posedge sck) disable iff (rst)
      opcode_r == see_pkg::OP_SR_RD && busy_s && !so_oe_n_r);
   c_pause: cover property (
      @(posedge sck) disable iff (rst)
      !hold_n && !frame_new_r);
   c_page_write: cover property (
      @(posedge sys_clk) disable iff (rst)
      $rose(sweep_r) && !sw_erase_r);
endmodule : see_core

// >>> inc/see_pkg.sv
// Constants shared by the serial EEPROM command front end
package see_pkg;
   // Array geometry
   localparam int          ADDR_W        = 17;
   localparam logic [16:0] ARRAY_LAST    = 17'h1ffff;
   localparam logic [7:0]  PAGE_LAST_OFS = 8'hff;
   localparam logic [14:0] SECT_LAST_OFS = 15'h7fff;
   localparam logic [7:0]  ERASED        = 8'hff;
   // Block-protect boundaries
   localparam logic [16:0] Q3_BASE       = 17'h18000;
   localparam logic [16:0] HALF_BASE     = 17'h10000;
   // Opcodes
   localparam logic [7:0]  OP_SR_WR      = 8'h01;
   localparam logic [7:0]  OP_WRITE      = 8'h02;
   localparam logic [7:0]  OP_READ       = 8'h03;
   localparam logic [7:0]  OP_LCLR       = 8'h04;
   localparam logic [7:0]  OP_SR_RD      = 8'h05;
   localparam logic [7:0]  OP_LSET       = 8'h06;
   localparam logic [7:0]  OP_PG_ER      = 8'h42;
   localparam logic [7:0]  OP_WAKE       = 8'hab;
   localparam logic [7:0]  OP_SLEEP      = 8'hb9;
   localparam logic [7:0]  OP_CE         = 8'hc7;
   localparam logic [7:0]  OP_SC_ER      = 8'hd8;
   // Status bit positions
   localparam int          ST_BUSY       = 0;
   localparam int          ST_LATCH      = 1;
   localparam int          ST_BPL        = 2;
   localparam int          ST_BPM        = 3;
   localparam int          ST_PEN        = 7;
   // Values after reset
   localparam logic [1:0]  BP_RST        = 2'h0;
   localparam logic        PEN_RST       = 1'b0;
   // Serial clock edge counts within a frame
   localparam logic [5:0]  CNT_OP        = 6'h08;
   localparam logic [5:0]  CNT_SR        = 6'h10;
   localparam logic [5:0]  CNT_ADDR      = 6'h20;
   localparam logic [5:0]  CNT_DATA      = 6'h28;
   // Internal write cycle, longest time rounded down
   localparam longint      T_WC_NS       = 5000000;
   localparam longint      CLK_NS        = 100;
   localparam int          WC_CYC        = int'(T_WC_NS / CLK_NS);
endpackage : see_pkg

// >>> sim/see_host.sv
// SPI host model that drives the serial link of the EEPROM front end
`timescale 1ns/1ps
module see_host (
   // Serial link
   output logic sck,
   output logic cs_n,
   output logic si,
   output logic hold_n,
   input  logic so_out,
   input  logic so_oe_n
);
   logic [7:0] tx[$];
   logic [7:0] rx[$];
   int         cut = 8;
   int         pause_at = -1;
   logic       drove;
   logic       so_last = 1'b0;
   // Released line shows the inverse of its last driven value
   always @(so_out or so_oe_n) if (!so_oe_n) so_last = so_out;
   wire so_v = so_oe_n ? ~so_last : so_out;
   // Idle: deselected, clock still and low
   initial begin
      {sck, cs_n, si, hold_n} = 4'b0101;
   end
   // Pause with the clock running and junk on the data line
   task pause();
      hold_n = 1'b0;
      repeat (2) begin
         si = ~si;
         #62.5 sck = 1'b1;
         #62.5 sck = 1'b0;
      end
      hold_n = 1'b1;
   endtask : pause
   // One frame: select, bytes MSB first, last byte maybe cut short
   task frame();
      logic [7:0] r;
      int         n;
      rx.delete();
      drove = 1'b0;
      n = 0;
      cs_n = 1'b0;
      #62.5;
      foreach (tx[b]) begin
         r = 8'h00;
         for (int i = 7; i >= 0; i--) begin
            if (b == tx.size() - 1 && 7 - i >= cut) break;
            if (n == pause_at) pause();
            si = tx[b][i];
            #62.5 sck = 1'b1;
            r[i] = so_v;
            drove = drove | ~so_oe_n;
            #62.5 sck = 1'b0;
            n++;
         end
         rx.push_back(r);
      end
      #62.5 cs_n = 1'b1;
      si = ~si;
      #500;
   endtask : frame
endmodule : see_host

// >>> sim/test_see_core.sv
// Self-checking bench for the serial EEPROM command front end
`timescale 1ns/1ps
module test_see_core;
   logic       sys_clk = 1'b0;
   logic       rst = 1'b1;
   logic       wp_n = 1'b1;
   logic       sck, cs_n, si, hold_n, so_out, so_oe_n;
   int         mismatches = 0;
   int         checks_done = 0;
   logic [7:0] mem[int];
   logic [7:0] q[$];
   always #50 sys_clk = ~sys_clk;
   // Design and host
   see_core #(.WC_CYC(20), .SIG_BYTE(8'h5a)) see_core_i (
      .sys_clk(sys_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
      .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n));
   see_host see_host_i (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
      .so_out(so_out), .so_oe_n(so_oe_n));
   // Expected status byte from its fields
   function automatic logic [7:0] st_exp(logic pen, logic [1:0] bp, logic lat, logic bsy);
      return {pen, 3'h0, bp, lat, bsy};
   endfunction : st_exp
   task results();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   task chk(string what, logic [7:0] exp, logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task go(int cut = 8);
      see_host_i.tx = q;
      see_host_i.cut = cut;
      see_host_i.frame();
   endtask : go
   task op(logic [7:0] c);
      q = '{c};
      go();
   endtask : op
   task st(logic [7:0] exp);
      q = '{see_pkg::OP_SR_RD, 8'h00};
      go();
      chk("status", exp, see_host_i.rx[1]);
   endtask : st
   // Poll busy under a bound
   task idle();
      int k;
      k = 0;
      do begin
         q = '{see_pkg::OP_SR_RD, 8'h00};
         go();
         k++;
      end while (see_host_i.rx[1][0] !== 1'b0 && k < 2000);
      if (see_host_i.rx[1][0] !== 1'b0) begin
         mismatches++;
         $display("BAD busy wait expected 0 seen 1");
         results();
      end
   endtask : idle
   // Page write of random bytes, mirrored with wrap in the model
   task wr(logic [23:0] a, int n, int pz);
      logic [7:0] d;
      op(see_pkg::OP_LSET);
      q = '{see_pkg::OP_WRITE, a[23:16], a[15:8], a[7:0]};
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         q.push_back(d);
         mem[int'({a[16:8], 8'(a[7:0] + i)})] = d;
      end
      see_host_i.pause_at = pz;
      go();
      see_host_i.pause_at = -1;
   endtask : wr
   task rd(logic [16:0] a, int n);
      q = '{see_pkg::OP_READ, {7'h7f, a[16]}, a[15:8], a[7:0]};
      for (int i = 0; i < n; i++) q.push_back(8'h00);
      go();
      for (int i = 0; i < n; i++) chk("read", mem[int'(17'(a + i))], see_host_i.rx[4 + i]);
   endtask : rd
   // Main sequence
   initial begin
      void'($urandom(29904));
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      #2000;
      st(st_exp(0, 0, 0, 0));
      $display("test reset done");
      q = '{see_pkg::OP_LSET, 8'h00};
      go(1);
      st(8'h00);
      op(see_pkg::OP_LSET);
      st(st_exp(0, 0, 1, 0));
      op(see_pkg::OP_LCLR);
      st(8'h00);
      q = '{see_pkg::OP_WRITE, 8'h00, 8'h00, 8'h00, 8'h55};
      go();
      st(8'h00);
      $display("test latch done");
      wr(24'hfffffe, 4, 37);
      st(st_exp(0, 0, 0, 1));
      q = '{see_pkg::OP_READ, 8'h00, 8'h00, 8'h00, 8'h00};
      go();
      chk("drive", 8'h00, {7'h0, see_host_i.drove});
      idle();
      wr(24'h000000, 1, -1);
      idle();
      rd(17'h1fffe, 3);
      rd(17'h1ff00, 2);
      chk("float", 8'h01, {7'h0, so_oe_n});
      $display("test page write done");
      op(see_pkg::OP_LSET);
      q = '{see_pkg::OP_WRITE, 8'h00, 8'h00, 8'h00, 8'($urandom)};
      go(4);
      st(st_exp(0, 0, 1, 0));
      rd(17'h00000, 1);
      $display("test partial write done");
      q = '{see_pkg::OP_SR_WR, 8'h84};
      go();
      idle();
      st(st_exp(1, 2'h1, 0, 0));
      @(posedge sys_clk) wp_n <= 1'b0;
      op(see_pkg::OP_LSET);
      q = '{see_pkg::OP_SR_WR, 8'h00};
      go();
      st(st_exp(1, 2'h1, 1, 0));
      op(see_pkg::OP_CE);
      st(st_exp(1, 2'h1, 1, 0));
      q = '{see_pkg::OP_PG_ER, 8'h01, 8'h80, 8'h00};
      go();
      st(st_exp(1, 2'h1, 1, 0));
      @(posedge sys_clk) wp_n <= 1'b1;
      q = '{see_pkg::OP_SR_WR, 8'h00};
      go();
      idle();
      st(8'h00);
      $display("test protect done");
      op(see_pkg::OP_LSET);
      q = '{see_pkg::OP_PG_ER, 8'h00, 8'h00, 8'h10};
      go();
      idle();
      mem[0] = see_pkg::ERASED;
      rd(17'h00000, 1);
      op(see_pkg::OP_LSET);
      q = '{see_pkg::OP_SC_ER, 8'h01, 8'hff, 8'h00};
      go();
      idle();
      mem[int'(17'h1fffe)] = see_pkg::ERASED;
      mem[int'(17'h1ffff)] = see_pkg::ERASED;
      rd(17'h1fffe, 2);
      st(8'h00);
      $display("test erase done");
      op(see_pkg::OP_SLEEP);
      q = '{see_pkg::OP_SR_RD, 8'h00};
      go();
      chk("sleep", 8'h00, {7'h0, see_host_i.drove});
      q = '{see_pkg::OP_WAKE, 8'h00, 8'h00, 8'h00, 8'h00};
      go();
      chk("signature", 8'h5a, see_host_i.rx[4]);
      st(8'h00);
      $display("test sleep done");
      results();
   end
endmodule : test_see_core
